// ===== sleep_pkg.sv
// Constants for the sleep-mode clock and power manager
package sleep_pkg;
  localparam logic [2:0] SM_IDLE = 3'h0;
  localparam logic [2:0] SM_NOISE = 3'h1;
  localparam logic [2:0] SM_PWR_DOWN = 3'h2;
  localparam logic [2:0] SM_PWR_SAVE = 3'h3;
  localparam logic [2:0] SM_STANDBY = 3'h6;
  localparam logic [2:0] SM_EXT_STANDBY = 3'h7;
  localparam int CLK_PERIOD_NS = 10;
  localparam int FAST_WAKE_CYCLES = 6;
  localparam int OSC_START_US = 16;
  localparam int OSC_START_CYCLES = OSC_START_US * 1000 / CLK_PERIOD_NS;
  localparam int CORE_HALT_CYCLES = 4;
  localparam int REGISTER_ADDR_W = 2;
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam int CTRL_SCAN_DIS_BIT = 0;
  localparam int STAT_MODE_LSB = 0;
endpackage

// ===== sleep_ctrl.sv
// Sleep-mode clock gating, oscillator and analog power control
//
// How it works
// - Select 111 with crystal clock enters extended standby, main oscillator kept.
// - Wake from standby and extended standby in six clock cycles.
// - Standby encodings ignored unless a crystal or resonator is the clock.
// - Async domain, timer oscillator only when async clock select set; timer wake too, except in idle.
// - Outside idle, external wake only from line 2 or level on lines 0, 1.
// - Enabled converter stays on in sleep; re-enable forces extended conversion.
// - Comparator forced off in all modes except idle and noise reduction.
// - Comparator using internal reference keeps reference powered in every mode.
// - Brown-out fuse programmed keeps detector on in all modes.
// - Enabled watchdog keeps running in all modes.
// - Reference powered when brown-out, comparator or converter needs it.
// - Input buffers off when I/O and converter clocks stop, wake pins kept.
// - Debug fuse keeps main clock on in power-down and power-save.
// - Scan port off when disable bit written or scan fuse unprogrammed.
// - Scan data out undriven while enabled and not shifting.
// - Select decodes idle, noise, down, save, standby; 100 and 101 reserved.
// - Power-save with async clock: timer 2 events wake when enabled.
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module sleep_ctrl #(
  parameter int OSC_START = sleep_pkg::OSC_START_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sleep_instr,
  input wire logic sleep_enable_bit,
  input wire logic [2:0] sleep_mode_select,
  input wire logic crystal_clock_sel,
  input wire logic async_timer_clock_select,
  input wire logic debug_enable_fuse,
  input wire logic scan_port_enable_fuse,
  input wire logic brownout_enable_fuse,
  input wire logic adc_enable,
  input wire logic acomp_enable,
  input wire logic acomp_uses_ref,
  input wire logic wdt_enable,
  input wire logic ext_irq_line_0,
  input wire logic ext_irq_line_1,
  input wire logic ext_irq_line_2,
  input wire logic irq01_level_mode,
  input wire logic two_wire_address_match,
  input wire logic timer2_irq,
  input wire logic spm_ready_irq,
  input wire logic adc_irq,
  input wire logic other_io_irq,
  input wire logic global_irq_enable,
  input wire logic tap_shifting,
  input wire logic tdo_data,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic clk_cpu_en,
  output logic clk_flash_en,
  output logic clk_io_en,
  output logic clk_adc_en,
  output logic async_clock_domain,
  output logic main_osc_en,
  output logic timer_osc_en,
  output logic adc_power,
  output logic adc_extended_conv,
  output logic acomp_power,
  output logic vref_power,
  output logic bod_power,
  output logic wdt_run,
  output logic input_buf_en,
  output logic wake_pin_buf_en,
  output logic scan_port_en,
  output logic tdo_out,
  output logic tdo_oe,
  output logic core_wake,
  output logic sleeping
);

  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,
    ST_SLEEP = 4'b0010,
    ST_START = 4'b0100,
    ST_HALT = 4'b1000
  } state_e;

  state_e state_q, state_d;
  logic [2:0] mode_q;
  logic scan_dis_q;
  logic adc_prev_q;
  logic ext_conv_q;
  logic [2:0] sy0_q, sy1_q;
  logic [31:0] cnt_q;

  // Wake pins cross two flip-flops first
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sy0_q <= 3'h0;
      sy1_q <= 3'h0;
    end else begin
      sy0_q <= {ext_irq_line_2, ext_irq_line_1, ext_irq_line_0};
      sy1_q <= sy0_q;
    end
  end

  wire is_standby = (sleep_mode_select == sleep_pkg::SM_STANDBY) ||
                    (sleep_mode_select == sleep_pkg::SM_EXT_STANDBY);
  wire sel_reserved = sleep_mode_select[2] && !sleep_mode_select[1];
  wire sel_ok = !sel_reserved && (!is_standby || crystal_clock_sel);
  wire enter = sleep_instr && sleep_enable_bit && sel_ok;

  wire in_sleep = (state_q == ST_SLEEP);
  wire m_idle = in_sleep && (mode_q == sleep_pkg::SM_IDLE);
  wire m_noise = in_sleep && (mode_q == sleep_pkg::SM_NOISE);
  wire m_down = in_sleep && (mode_q == sleep_pkg::SM_PWR_DOWN);
  wire m_save = in_sleep && (mode_q == sleep_pkg::SM_PWR_SAVE);
  wire m_stby = in_sleep && (mode_q == sleep_pkg::SM_STANDBY);
  wire m_xstby = in_sleep && (mode_q == sleep_pkg::SM_EXT_STANDBY);
  wire fast_mode = (mode_q == sleep_pkg::SM_STANDBY) ||
                   (mode_q == sleep_pkg::SM_EXT_STANDBY) ||
                   (mode_q == sleep_pkg::SM_IDLE) || (mode_q == sleep_pkg::SM_NOISE);
  wire async_ok = async_timer_clock_select;

  wire io_on = !in_sleep || m_idle;
  wire adc_clk_on = !in_sleep || m_idle || m_noise;
  wire asy_on = !in_sleep || ((m_idle || m_noise || m_save || m_xstby) && async_ok);
  wire main_on = !in_sleep || m_idle || m_noise || m_stby || m_xstby ||
                 ((m_down || m_save) && debug_enable_fuse);
  wire timer_on = asy_on;

  wire ext_level = (sy1_q[0] || sy1_q[1]) && irq01_level_mode;
  wire ext_wake = m_idle ? |sy1_q : (sy1_q[2] || ext_level);
  wire t2_wake = timer2_irq && global_irq_enable &&
                 (m_idle || ((m_noise || m_save || m_xstby) && async_ok));
  wire wake = ext_wake || two_wire_address_match || t2_wake ||
              ((m_idle || m_noise) && (spm_ready_irq || adc_irq)) ||
              (m_idle && other_io_irq);

  wire acomp_on = acomp_enable && (!in_sleep || m_idle || m_noise);
  wire ref_keep = acomp_enable && acomp_uses_ref;
  wire vref_on = brownout_enable_fuse || acomp_on || ref_keep || adc_enable;
  wire scan_on = scan_port_enable_fuse && !scan_dis_q;
  wire [31:0] start_len = fast_mode ? sleep_pkg::FAST_WAKE_CYCLES : OSC_START;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: if (enter) state_d = ST_SLEEP;
      ST_SLEEP: if (wake) state_d = ST_START;
      ST_START: if (cnt_q + 32'h0000_0001 >= start_len) state_d = ST_RUN;
      ST_HALT: state_d = ST_RUN;
      default: state_d = ST_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_RUN;
      mode_q <= sleep_pkg::SM_IDLE;
      cnt_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      if (enter && state_q == ST_RUN) mode_q <= sleep_mode_select;
      cnt_q <= (state_q == ST_START) ? cnt_q + 32'h0000_0001 : 32'h0000_0000;
    end
  end

  // Converter off-to-on sets a pending extended conversion
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      adc_prev_q <= 1'b0;
      ext_conv_q <= 1'b0;
    end else begin
      adc_prev_q <= adc_enable;
      if (adc_enable && !adc_prev_q) ext_conv_q <= 1'b1;
      else if (adc_irq) ext_conv_q <= 1'b0;
    end
  end

  wire sel_ctrl = (reg_addr == sleep_pkg::REG_CTRL);
  wire sel_stat = (reg_addr == sleep_pkg::REG_STATUS);
  wire [7:0] stat_word = {1'b0, scan_on, in_sleep, 2'h0, mode_q};
  wire [7:0] rd_mux = sel_ctrl ? {7'h00, scan_dis_q} : (sel_stat ? stat_word : 8'h00);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scan_dis_q <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      if (reg_wr && sel_ctrl) scan_dis_q <= reg_wdata[sleep_pkg::CTRL_SCAN_DIS_BIT];
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

  // Core and program-memory clocks stop for the whole stay in sleep
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_cpu_en <= 1'b1;
      clk_flash_en <= 1'b1;
    end else begin
      clk_cpu_en <= (state_d == ST_RUN);
      clk_flash_en <= (state_d == ST_RUN);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_io_en <= 1'b1;
      clk_adc_en <= 1'b1;
    end else begin
      clk_io_en <= io_on;
      clk_adc_en <= adc_clk_on;
    end
  end

  // Async domain and its oscillator only with the async clock selected
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      async_clock_domain <= 1'b0;
      timer_osc_en <= 1'b0;
    end else begin
      async_clock_domain <= asy_on && async_ok;
      timer_osc_en <= timer_on && async_ok;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      main_osc_en <= 1'b1;
      adc_power <= 1'b0;
    end else begin
      main_osc_en <= main_on;
      adc_power <= adc_enable;
    end
  end

  // Comparator follows the mode; the reference is kept on apart
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      adc_extended_conv <= 1'b0;
      acomp_power <= 1'b0;
    end else begin
      adc_extended_conv <= ext_conv_q;
      acomp_power <= acomp_on;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      vref_power <= 1'b0;
      bod_power <= 1'b0;
    end else begin
      vref_power <= vref_on;
      bod_power <= brownout_enable_fuse;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wdt_run <= 1'b0;
      input_buf_en <= 1'b1;
    end else begin
      wdt_run <= wdt_enable;
      input_buf_en <= io_on || adc_clk_on;
    end
  end

  // Wake pins keep their buffers in every mode
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_pin_buf_en <= 1'b1;
      scan_port_en <= 1'b0;
    end else begin
      wake_pin_buf_en <= 1'b1;
      scan_port_en <= scan_on;
    end
  end

  // Scan data out driven only while shifting
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tdo_out <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      tdo_out <= tdo_data;
      tdo_oe <= scan_on && tap_shifting;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      core_wake <= 1'b0;
      sleeping <= 1'b0;
    end else begin
      core_wake <= (state_q == ST_START) && (state_d == ST_RUN);
      sleeping <= (state_d == ST_SLEEP);
    end
  end

endmodule

// ===== core_model.sv
// Core model issuing sleep instructions
`timescale 1ns/1ps
module core_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic go,
  input wire logic se_want,
  output logic sleep_instr,
  output logic sleep_enable_bit
);
  // Enable bit is set in the same cycle as the one-cycle sleep pulse
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sleep_instr <= 1'b0;
      sleep_enable_bit <= 1'b0;
    end else begin
      sleep_instr <= go;
      sleep_enable_bit <= se_want;
    end
  end
endmodule

// ===== sleep_ctrl_checker.sv
// Port assertions for the sleep controller
`timescale 1ns/1ps
module sleep_ctrl_checker (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sleep_instr,
  input wire logic sleep_enable_bit,
  input wire logic [2:0] sleep_mode_select,
  input wire logic crystal_clock_sel,
  input wire logic brownout_enable_fuse,
  input wire logic acomp_enable,
  input wire logic acomp_uses_ref,
  input wire logic tap_shifting,
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic clk_cpu_en,
  input wire logic clk_io_en,
  input wire logic main_osc_en,
  input wire logic acomp_power,
  input wire logic vref_power,
  input wire logic bod_power,
  input wire logic scan_port_en,
  input wire logic tdo_oe,
  input wire logic sleeping
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire take = sleep_instr && sleep_enable_bit && !sleeping && clk_cpu_en;
  a_idle_entry: assert property (take && sleep_mode_select == 3'h0 |=> sleeping
    && !clk_cpu_en && clk_io_en && main_osc_en) else $error("idle entry");
  a_reserved_sel: assert property (take && sleep_mode_select[2:1] == 2'b10 |=> !sleeping)
    else $error("reserved mode entered");
  a_standby_xtal: assert property (take && sleep_mode_select[2:1] == 2'b11
    && !crystal_clock_sel |=> !sleeping) else $error("standby without crystal");
  a_deep_acomp: assert property (take && sleep_mode_select == 3'h2 |=> ##1
    !acomp_power && !clk_io_en) else $error("comparator on in power-down");
  a_bod_kept: assert property (brownout_enable_fuse |=> bod_power)
    else $error("brown-out off");
  a_vref_on: assert property (acomp_enable && acomp_uses_ref |=> vref_power)
    else $error("reference off");
  a_scan_dis: assert property (reg_wr && reg_addr == 2'h0 && reg_wdata[0]
    |-> ##[1:2] !scan_port_en) else $error("scan port still on");
  a_tdo_float: assert property (!tap_shifting |=> !tdo_oe)
    else $error("tdo driven");
endmodule
bind sleep_ctrl sleep_ctrl_checker i_sleep_ctrl_checker (.*);

// ===== tb_top.sv
// Self-checking testbench for the sleep controller
`timescale 1ns/1ps
module tb_top;
  localparam int OSC = 20;
  logic clk = 0, arst_n = 0, go = 0, se_want = 0, crystal_clock_sel = 0;
  logic [2:0] sleep_mode_select = 3'h0;
  logic async_timer_clock_select = 0, debug_enable_fuse = 0, scan_port_enable_fuse = 1;
  logic brownout_enable_fuse = 1, adc_enable = 0, acomp_enable = 1, acomp_uses_ref = 1;
  logic wdt_enable = 1, ext_irq_line_0 = 0, ext_irq_line_1 = 0, ext_irq_line_2 = 0;
  logic irq01_level_mode = 0, two_wire_address_match = 0, timer2_irq = 0, spm_ready_irq = 0;
  logic adc_irq = 0, other_io_irq = 0, global_irq_enable = 0, tap_shifting = 0, tdo_data = 0;
  logic reg_wr = 0, reg_rd = 0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic sleep_instr, sleep_enable_bit, clk_cpu_en, clk_flash_en, clk_io_en, clk_adc_en;
  logic async_clock_domain, main_osc_en, timer_osc_en, adc_power, adc_extended_conv;
  logic acomp_power, vref_power, bod_power, wdt_run, input_buf_en, wake_pin_buf_en;
  logic scan_port_en, tdo_out, tdo_oe, core_wake, sleeping;
  int bad_count = 0, tests_run = 0;
  always #5 clk = ~clk;
  sleep_ctrl #(.OSC_START(OSC)) i_sleep_ctrl (.*);
  core_model i_core_model (.*);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  task automatic sl(input logic s, input logic [2:0] m);
    @(posedge clk);
    sleep_mode_select <= m;
    se_want <= s;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic misc();
    repeat (2) @(posedge clk);
    #1 chk({bod_power, wdt_run, vref_power, wake_pin_buf_en}, 4'hf);
    chk({clk_flash_en, clk_adc_en, input_buf_en, adc_power}, 4'he);
    tap_shifting <= 1'b1;
    tdo_data <= 1'b1;
    adc_enable <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk({tdo_oe, tdo_out, scan_port_en, adc_extended_conv}, 4'hf);
    chk(adc_power, 1'b1);
    {tap_shifting, adc_enable} <= 2'b00;
  endtask
  // Counts cycles from wake source to the core release pulse
  task automatic wt(input int lo, input int hi);
    int n;
    n = 0;
    while (core_wake !== 1'b1 && n < 2000) begin
      @(posedge clk);
      #1 n++;
    end
    chk(8'(n >= lo && n <= hi), 8'h01);
    {ext_irq_line_0, ext_irq_line_2, other_io_irq, timer2_irq} <= 4'h0;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    misc();
    rd(2'h1, 8'h40);
    wr(2'h0, 8'h01);
    rd(2'h1, 8'h00);
    rd(2'h3, 8'h00);
    wr(2'h0, 8'h00);
    sl(1'b0, 3'h0);
    chk(sleeping, 1'b0);
    sl(1'b1, 3'h5);
    chk(sleeping, 1'b0);
    sl(1'b1, 3'h7);
    chk(sleeping, 1'b0);
    sl(1'b1, 3'h0);
    chk({sleeping, clk_cpu_en, clk_io_en, main_osc_en}, 4'hb);
    other_io_irq <= 1'b1;
    wt(1, 12);
    debug_enable_fuse <= 1'b1;
    sl(1'b1, 3'h2);
    chk({clk_io_en, main_osc_en, acomp_power}, 3'h2);
    ext_irq_line_0 <= 1'b1;
    repeat (8) @(posedge clk);
    #1 chk(sleeping, 1'b1);
    irq01_level_mode <= 1'b1;
    wt(OSC, OSC + 12);
    debug_enable_fuse <= 1'b0;
    async_timer_clock_select <= 1'b1;
    global_irq_enable <= 1'b1;
    sl(1'b1, 3'h3);
    chk({async_clock_domain, timer_osc_en, main_osc_en}, 3'h6);
    timer2_irq <= 1'b1;
    wt(OSC, OSC + 12);
    crystal_clock_sel <= 1'b1;
    sl(1'b1, 3'h7);
    chk({sleeping, main_osc_en, clk_io_en, async_clock_domain}, 4'hd);
    ext_irq_line_2 <= 1'b1;
    wt(1, 12);
    results();
  end
  initial begin
    #100000;
    bad_count++;
    results();
  end
endmodule
